// >>> timing_defines.vh
// constants for instruction cycle decode and state timing
`ifndef TIMING_DEFINES_VH
`define TIMING_DEFINES_VH
// access locations
`define LOC_ONCHIP_MEM   2'h0
`define LOC_ONCHIP_REG   2'h1
`define LOC_EXTERNAL     2'h2
// state costs per cycle type
`define COST_FETCH_MEM   8'h02
`define COST_WORD_REG    8'h06
`define COST_BYTE_REG    8'h03
`define COST_INTERNAL    8'h01
// cycle counts
`define CNT_BRANCH_FETCH 4'h2
`define CNT_MULDIV_INT   4'hC
`define CNT_STACKMOV_INT 4'h2
// cycle type index
`define CYC_FETCH        3'h0
`define CYC_BRANCH       3'h1
`define CYC_STACK        3'h2
`define CYC_BYTE         3'h3
`define CYC_WORD         3'h4
`define CYC_INTERNAL     3'h5
`endif

// >>> cycle_cost.v
// state cost of one cycle type at one access location
`timescale 1ns/1ps
`default_nettype none
`include "timing_defines.vh"
module cycle_cost
(
    // selection
    input  wire [2:0] cyc_type,
    input  wire [1:0] loc,
    input  wire [3:0] wait_states,
    // result
    output reg  [7:0] cost
);
    always @*
    begin
        cost = `COST_INTERNAL;
        if (cyc_type == `CYC_INTERNAL)
            cost = `COST_INTERNAL;
        else if (cyc_type == `CYC_BYTE)
        begin
            if (loc == `LOC_EXTERNAL)
                cost = `COST_BYTE_REG + {4'h0, wait_states};
            else
                cost = `COST_BYTE_REG;
        end
        else
        begin
            if (loc == `LOC_EXTERNAL)
                cost = `COST_WORD_REG + {3'h0, wait_states, 1'b0};
            else if (loc == `LOC_ONCHIP_MEM && cyc_type == `CYC_FETCH)
                cost = `COST_FETCH_MEM;
            else
                cost = `COST_WORD_REG;
        end
    end
endmodule // cycle_cost
`default_nettype wire

// >>> instruction_state_timing.v
// opcode decode into cycle counts and total execution states
`timescale 1ns/1ps
`default_nettype none
`include "timing_defines.vh"
module instruction_state_timing
(
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // request
    input  wire        start,
    input  wire [15:0] opcode,
    input  wire [7:0]  gpr4_low_byte,
    input  wire [3:0]  wait_states,
    input  wire [1:0]  loc_fetch,
    input  wire [1:0]  loc_data,
    input  wire [1:0]  loc_stack,
    // answer
    output reg         done,
    output reg  [15:0] exec_states,
    output reg         unknown_op
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SUM  = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [1:0]  state_reg, state_next;
    reg [2:0]  idx_reg;
    reg [15:0] acc_reg;
    reg [9:0]  cnt_reg [0:5];
    reg [1:0]  loc_reg [0:5];
    reg [3:0]  ws_reg;
    reg        unk_reg;

    // block move needs ten bits: 2n+2 reaches 512
    reg [9:0] c_i, c_j, c_k, c_l, c_m, c_n;
    reg       unk;
    wire [7:0] hi = opcode[15:8];
    wire       b7 = opcode[7];
    wire [7:0] cost;
    // largest product is 512 x 18, well inside 16 bits
    wire [17:0] prod = cnt_reg[idx_reg] * cost;

    // default fetch count for one-word instructions
    always @*
    begin
        c_i = 10'h001;
        c_j = 10'h000;
        c_k = 10'h000;
        c_l = 10'h000;
        c_m = 10'h000;
        c_n = 10'h000;
        unk = 1'b0;
        case (hi[7:4])
        4'h4: c_i = {6'h00, `CNT_BRANCH_FETCH};
        4'h6, 4'h7:
        begin
            case (hi)
            8'h68: c_l = 10'h001;
            8'h69: c_m = 10'h001;
            8'h6C:
            begin
                c_l = 10'h001;
                c_n = {6'h00, `CNT_STACKMOV_INT};
            end
            // push/pop share this code
            8'h6D:
            begin
                c_m = 10'h001;
                c_n = {6'h00, `CNT_STACKMOV_INT};
            end
            8'h6E:
            begin
                c_i = 10'h002;
                c_l = 10'h001;
            end
            8'h6F:
            begin
                c_i = 10'h002;
                c_m = 10'h001;
            end
            // peripheral-sync forms fall in here as plain absolute moves
            8'h6A:
            begin
                c_i = b7 ? 10'h001 : 10'h002;
                c_l = 10'h001;
            end
            8'h6B:
            begin
                c_i = 10'h002;
                c_m = 10'h001;
            end
            8'h79: c_i = 10'h002;
            8'h7B:
            begin
                c_i = 10'h002;
                c_n = 10'h001;
                c_l = {1'b0, gpr4_low_byte, 1'b0} + 10'h002;
            end
            8'h7C, 8'h7E:
            begin
                c_i = 10'h002;
                c_l = 10'h001;
            end
            8'h7D, 8'h7F:
            begin
                c_i = 10'h002;
                c_l = 10'h002;
            end
            default: c_i = 10'h001;
            endcase
        end
        4'h5:
        begin
            case (hi)
            8'h50, 8'h51: c_n = {6'h00, `CNT_MULDIV_INT};
            8'h54:
            begin
                c_i = 10'h002;
                c_k = 10'h001;
                c_n = 10'h002;
            end
            8'h55:
            begin
                c_i = 10'h002;
                c_k = 10'h001;
            end
            8'h56:
            begin
                c_i = 10'h002;
                c_k = 10'h002;
                c_n = 10'h002;
            end
            8'h59: c_i = 10'h002;
            8'h5A:
            begin
                c_i = 10'h002;
                c_n = 10'h002;
            end
            8'h5B:
            begin
                c_i = 10'h002;
                c_j = 10'h001;
                c_n = 10'h002;
            end
            8'h5D:
            begin
                c_i = 10'h002;
                c_k = 10'h001;
            end
            8'h5E:
            begin
                c_i = 10'h002;
                c_k = 10'h001;
                c_n = 10'h002;
            end
            8'h5F:
            begin
                c_i = 10'h002;
                c_j = 10'h001;
                c_k = 10'h001;
            end
            default: unk = 1'b1;
            endcase
        end
        4'h2, 4'h3: c_l = 10'h001;
        default: c_i = 10'h001;
        endcase
    end

    cycle_cost u_cost
    (
        .cyc_type    (idx_reg),
        .loc         (loc_reg[idx_reg]),
        .wait_states (ws_reg),
        .cost        (cost)
    );

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
        ST_IDLE: if (start) state_next = ST_SUM;
        ST_SUM:  if (idx_reg == `CYC_INTERNAL) state_next = ST_DONE;
        ST_DONE: state_next = ST_IDLE;
        default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            idx_reg <= 3'h0;
            acc_reg <= 16'h0000;
            ws_reg <= 4'h0;
            unk_reg <= 1'b0;
            done <= 1'b0;
            exec_states <= 16'h0000;
            unknown_op <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            done <= (state_reg == ST_DONE);
            if (state_reg == ST_IDLE && start)
            begin
                cnt_reg[0] <= c_i;
                cnt_reg[1] <= c_j;
                cnt_reg[2] <= c_k;
                cnt_reg[3] <= c_l;
                cnt_reg[4] <= c_m;
                cnt_reg[5] <= c_n;
                loc_reg[0] <= loc_fetch;
                loc_reg[1] <= loc_data;
                loc_reg[2] <= loc_stack;
                loc_reg[3] <= loc_data;
                loc_reg[4] <= loc_data;
                loc_reg[5] <= `LOC_ONCHIP_MEM;
                ws_reg <= wait_states;
                unk_reg <= unk;
                idx_reg <= 3'h0;
                acc_reg <= 16'h0000;
            end
            else if (state_reg == ST_SUM)
            begin
                acc_reg <= acc_reg + prod[15:0];
                // index parks on the last type so it never leaves the tables
                if (idx_reg != `CYC_INTERNAL)
                    idx_reg <= idx_reg + 3'h1;
            end
            else if (state_reg == ST_DONE)
            begin
                exec_states <= unk_reg ? 16'h0000 : acc_reg;
                unknown_op <= unk_reg;
            end
        end
    end
endmodule // instruction_state_timing
`default_nettype wire

// >>> location_model.sv
// access location and wait profile model
`timescale 1ns/1ps
`default_nettype none
module location_model
(
    // profile choice
    input  wire logic [1:0] profile,
    // locations and waits
    output logic      [1:0] loc_fetch,
    output logic      [1:0] loc_data,
    output logic      [1:0] loc_stack,
    output logic      [3:0] wait_states
);
    assign loc_fetch   = (profile == 2'h1) ? 2'h2 : 2'h0;
    assign loc_data    = (profile == 2'h0) ? 2'h0 : (profile == 2'h2) ? 2'h1 : 2'h2;
    // stack kept apart from data in profile 3 so a mixed-up location shows
    assign loc_stack   = (profile == 2'h3) ? 2'h1 : loc_data;
    // one wait count for every external access
    assign wait_states = (profile == 2'h1) ? 4'h3 : (profile == 2'h3) ? 4'hF : 4'h0;
endmodule // location_model
`default_nettype wire

// >>> instruction_state_timing_props.sv
// assertions on instruction timing ports
`timescale 1ns/1ps
`default_nettype none
module instruction_state_timing_props
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // request and answer
    input wire logic        start,
    input wire logic [15:0] opcode,
    input wire logic [3:0]  wait_states,
    input wire logic [1:0]  loc_fetch,
    input wire logic        done,
    input wire logic [15:0] exec_states,
    input wire logic        unknown_op
);
    reg        busy_reg;
    reg [15:0] op_reg;
    reg [1:0]  lf_reg;
    reg [3:0]  m_reg;
    wire       take = start && (!busy_reg || done);
    always @(posedge mclk)
    begin
        if (!rst_n)
            busy_reg <= 1'b0;
        else
            busy_reg <= take || (busy_reg && !done);
        if (take)
        begin
            op_reg <= opcode;
            lf_reg <= loc_fetch;
            m_reg  <= wait_states;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_lat; take |-> ##[8:9] done; endproperty
    a_lat: assert property (p_lat) else $error("done late");
    property p_pulse; done |=> !done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_idle; !busy_reg |-> !done; endproperty
    a_idle: assert property (p_idle) else $error("done without start");
    property p_hold; !$stable(exec_states) |-> done; endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_br; done && op_reg[15:12] == 4'h4 && lf_reg == 2'h0 |-> exec_states == 16'h0004;
    endproperty
    a_br: assert property (p_br) else $error("branch states");
    property p_ext; done && op_reg[15:12] == 4'h4 && lf_reg == 2'h2
        |-> exec_states == {10'h000, m_reg, 2'h0} + 16'h000C; endproperty
    a_ext: assert property (p_ext) else $error("external branch states");
    property p_md; done && op_reg[15:9] == 7'h28 && lf_reg == 2'h0 |-> exec_states == 16'h000E;
    endproperty
    a_md: assert property (p_md) else $error("multiply states");
    property p_nop; done && op_reg == 16'h0000 && lf_reg == 2'h2
        |-> exec_states == {11'h000, m_reg, 1'b0} + 16'h0006; endproperty
    a_nop: assert property (p_nop) else $error("nop states");
    property p_known; done && op_reg[15:12] == 4'h4 |-> !unknown_op; endproperty
    a_known: assert property (p_known) else $error("branch unknown");
    property p_unk; done && unknown_op |-> exec_states == 16'h0000; endproperty
    a_unk: assert property (p_unk) else $error("unknown op has states");
    c_unk: cover property (done && unknown_op);
    c_br: cover property (done && op_reg[15:12] == 4'h4);
    c_md: cover property (done && op_reg[15:9] == 7'h28);
    c_bm: cover property (done && op_reg == 16'h7B5C);
endmodule // instruction_state_timing_props
bind instruction_state_timing instruction_state_timing_props u_props (.mclk(mclk),
    .rst_n(rst_n), .start(start), .opcode(opcode), .wait_states(wait_states),
    .loc_fetch(loc_fetch), .done(done), .exec_states(exec_states), .unknown_op(unknown_op));
`default_nettype wire

// >>> instruction_state_timing_test.sv
// testbench for instruction state timing
`timescale 1ns/1ps
`default_nettype none
module instruction_state_timing_test;
    reg         mclk = 1'b0, rst_n = 1'b0, start = 1'b0;
    reg  [15:0] opcode = 16'h0000;
    reg  [7:0]  gpr4_low_byte = 8'h00;
    reg  [1:0]  profile = 2'h0;
    wire [1:0]  loc_fetch, loc_data, loc_stack;
    wire [3:0]  wait_states;
    wire        done, unknown_op;
    wire [15:0] exec_states;
    integer     error_cnt = 0, compares = 0;
    always #12.5 mclk = ~mclk;
    location_model u_loc (.profile(profile), .loc_fetch(loc_fetch), .loc_data(loc_data),
        .loc_stack(loc_stack), .wait_states(wait_states));
    instruction_state_timing u_dut (.mclk(mclk), .rst_n(rst_n), .start(start), .opcode(opcode),
        .gpr4_low_byte(gpr4_low_byte), .wait_states(wait_states), .loc_fetch(loc_fetch),
        .loc_data(loc_data), .loc_stack(loc_stack), .done(done), .exec_states(exec_states),
        .unknown_op(unknown_op));
    task check(input [15:0] seen, input [15:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task summarize;
    begin
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task run(input [15:0] op, input [7:0] n, input [1:0] pr);
        integer i;
    begin
        @(posedge mclk);
        opcode <= op; gpr4_low_byte <= n; profile <= pr; start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        i = 0;
        @(negedge mclk);
        while (done !== 1'b1 && i < 20)
        begin
            @(negedge mclk);
            i = i + 1;
        end
        check({15'h0000, done}, 16'h0001);
    end
    endtask
    task t_branch;
        integer k;
    begin
        for (k = 0; k < 4; k = k + 1)
        begin
            run({5'h08, k[1], 1'b0, k[0], 8'h12}, 8'h00, 2'h0);
            check(exec_states, 16'h0004);
            run({5'h08, k[1], 1'b0, k[0], 8'h12}, 8'h00, 2'h1);
            check(exec_states, 16'h0018);
        end
    end
    endtask
    task t_muldiv;
    begin
        run(16'h5023, 8'h00, 2'h0);
        check(exec_states, 16'h000E);
        run(16'h5123, 8'h00, 2'h1);
        check(exec_states, 16'h0018);
    end
    endtask
    task t_block_move;
    begin
        run(16'h7B5C, 8'hFF, 2'h2);
        check(exec_states, 16'h0605);
        run(16'h7B5C, 8'h00, 2'h3);
        check(exec_states, 16'h0029);
        run(16'h7B5C, 8'hFF, 2'h3);
        check(exec_states, 16'h2405);
    end
    endtask
    task t_stack;
    begin
        run(16'h5470, 8'h00, 2'h1);
        check(exec_states, 16'h0026);
        run(16'h5470, 8'h00, 2'h3);
        check(exec_states, 16'h000C);
        run(16'h5F30, 8'h00, 2'h1);
        check(exec_states, 16'h0030);
        run(16'h5F30, 8'h00, 2'h3);
        check(exec_states, 16'h002E);
    end
    endtask
    task t_move;
    begin
        run(16'h6DF0, 8'h00, 2'h2);
        check(exec_states, 16'h000A);
        run(16'h6D70, 8'h00, 2'h3);
        check(exec_states, 16'h0028);
        run(16'h6A40, 8'h00, 2'h2);
        check(exec_states, 16'h0007);
        run(16'h6A00, 8'h00, 2'h2);
        check(exec_states, 16'h0007);
        run(16'h6AC0, 8'h00, 2'h2);
        check(exec_states, 16'h0005);
    end
    endtask
    task t_unknown;
    begin
        run(16'h5200, 8'h00, 2'h0);
        check(exec_states, 16'h0000);
        check({15'h0000, unknown_op}, 16'h0001);
    end
    endtask
    task t_nop;
    begin
        run(16'h0000, 8'h00, 2'h1);
        check(exec_states, 16'h000C);
        check({15'h0000, unknown_op}, 16'h0000);
    end
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_branch;
        t_muldiv;
        t_block_move;
        t_stack;
        t_move;
        t_unknown;
        t_nop;
        summarize;
    end
    initial
    begin
        #75000;
        error_cnt = error_cnt + 1;
        summarize;
    end
endmodule // instruction_state_timing_test
`default_nettype wire
